// *** qcc_control.sv ***
// APB encoder counter control: mode, prescale, gating and index reset
//
// Chosen here: the address map and register access over APB.
`include "qcc_consts.svh"
`default_nettype none
// Operation
// - Prescale code divides timer clock by 2**code; external edges count only on a prescale tick; mode 00 unscaled
// - Invert 0 counts up unless external down (mode 00: unless phase B leads)
// - Gate enable lets external gate stop counting
// - Mode 11 runs internal timer
// - Mode 10 counts external clock
// - Mode 01 external clock with external direction
// - Mode 00 x4 quadrature decode
// - Modes 10/11 timers, init mode ignored
// - Quadrature index match resets position counter
// - Match uses swapped, polarity-adjusted phases
module qcc_control #(
    parameter int DIV_W = 3,
    parameter int POS_W = 32
) (
    input  wire logic                    CLK,
    input  wire logic                    RESET,
    input  wire logic                    PSEL,
    input  wire logic                    PENABLE,
    input  wire logic                    PWRITE,
    input  wire logic [11:0]             PADDR,
    input  wire logic [31:0]             PWDATA,
    output logic      [31:0]             PRDATA,
    output logic                         PREADY,
    output logic                         PSLVERR,
    input  wire qcc_pkg::qcc_pins_s      PINS,
    output logic      [POS_W-1:0]        POSITION,
    output logic                         COUNT_TICK,
    output logic                         COUNT_UP,
    output logic                         TIMER_MODE,
    output logic      [2:0]              INIT_MODE
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [15:0]      ctrl;
        logic [15:0]      phase;
        logic [POS_W-1:0] pos;
        logic [31:0]      rdata;
        logic             ext_clk_d;
        logic             tick;
        logic             up;
        logic             index_hit;
    } qcc_state_s;

    qcc_state_s st_reg;
    qcc_state_s st_next;

    qcc_pkg::qcc_cfg_s cfg;
    logic              pre_tick;
    logic              cond_a;
    logic              cond_b;
    logic              q_step;
    logic              q_up;
    logic              ext_edge;
    logic              gate_ok;
    logic              raw_step;
    logic              raw_up;
    logic              match;
    logic              wr;
    logic              rd;
    logic              hit;

    if (DIV_W != 3) begin : g_bad_div
        $error("DIV_W must be 3 for this register layout");
    end
    if (POS_W < 17 || POS_W > 32) begin : g_bad_pos
        $error("POS_W must be 17..32");
    end

    // ************************************************************
    // Submodules
    // ************************************************************
    qcc_prescaler #(
        .DIV_W   (DIV_W)
    ) u_pre (
        .CLK     (CLK),
        .RESET   (RESET),
        .DIV_SEL (cfg.div_sel),
        .TICK    (pre_tick)
    );

    qcc_phase_cond u_pc (
        .CLK     (CLK),
        .RESET   (RESET),
        .PHASE_A (PINS.phase_a),
        .PHASE_B (PINS.phase_b),
        .SWAP    (st_reg.phase[`QCC_SWAP_BIT]),
        .A_POL   (st_reg.phase[`QCC_APOL_BIT]),
        .B_POL   (st_reg.phase[`QCC_BPOL_BIT]),
        .COND_A  (cond_a),
        .COND_B  (cond_b),
        .STEP    (q_step),
        .STEP_UP (q_up)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_next = st_reg;
        cfg.mode    = qcc_pkg::qcc_mode_e'(
            st_reg.ctrl[`QCC_CCM_MSB:`QCC_CCM_LSB]);
        cfg.gate_en = st_reg.ctrl[`QCC_GATE_BIT];
        cfg.dir_inv = st_reg.ctrl[`QCC_DIR_BIT];
        cfg.div_sel = st_reg.ctrl[`QCC_DIV_MSB:`QCC_DIV_LSB];
        cfg.pim     = st_reg.ctrl[`QCC_PIM_MSB:`QCC_PIM_LSB];

        wr = PSEL && PENABLE && PWRITE;
        rd = PSEL && !PENABLE && !PWRITE;
        ext_edge = PINS.ext_clk && !st_reg.ext_clk_d;
        st_next.ext_clk_d = PINS.ext_clk;
        // Gate ignored unless enabled
        gate_ok = !cfg.gate_en || PINS.gate;

        // Mode select; only quadrature decode is not prescaled, the
        // decoder samples every cycle so the prescaled clock limit is
        // the encoder's concern
        case (cfg.mode)
            qcc_pkg::QCC_MODE_QUAD: begin
                raw_step = q_step;
                raw_up   = q_up;
            end
            qcc_pkg::QCC_MODE_EXTDIR: begin
                raw_step = ext_edge;
                raw_up   = PINS.ext_up;
            end
            qcc_pkg::QCC_MODE_EXTCLK: begin
                raw_step = ext_edge;
                raw_up   = PINS.ext_up;
            end
            default: begin
                raw_step = pre_tick;
                raw_up   = PINS.ext_up;
            end
        endcase
        if (cfg.mode != qcc_pkg::QCC_MODE_QUAD &&
            cfg.mode != qcc_pkg::QCC_MODE_TIMER) begin
            raw_step = raw_step && pre_tick;
        end

        // External up level drives up outside quadrature mode (decoder direction in mode 00); invert flips sense
        st_next.up   = raw_up ^ cfg.dir_inv;
        st_next.tick = raw_step && gate_ok;

        // Index match in quadrature mode only
        match = (cfg.mode == qcc_pkg::QCC_MODE_QUAD)
            && ({cond_a, cond_b}
                == st_reg.phase[`QCC_IMV_MSB:`QCC_IMV_LSB]);
        hit = match;
        st_next.index_hit = st_reg.index_hit || hit;

        if (hit) begin
            st_next.pos = '0;
        end else if (st_next.tick) begin
            st_next.pos = st_next.up ? st_reg.pos + 1'b1
                                     : st_reg.pos - 1'b1;
        end

        // Register writes
        if (wr) begin
            if (PADDR == `QCC_ADDR_CTRL) begin
                st_next.ctrl = PWDATA[15:0] & `QCC_CTRL_WMASK;
            end else if (PADDR == `QCC_ADDR_PHASE) begin
                st_next.phase = PWDATA[15:0] & `QCC_PHASE_WMASK;
            end else if (PADDR == `QCC_ADDR_STATUS) begin
                // Hit in same cycle wins over the clear
                if (PWDATA[0] && !hit) begin
                    st_next.index_hit = 1'b0;
                end
            end
        end

        // Read data captured in setup phase
        if (rd) begin
            if (PADDR == `QCC_ADDR_CTRL) begin
                st_next.rdata = {16'h0000, st_reg.ctrl};
            end else if (PADDR == `QCC_ADDR_PHASE) begin
                st_next.rdata = {16'h0000, st_reg.phase};
            end else if (PADDR == `QCC_ADDR_POS_LOW) begin
                st_next.rdata = {16'h0000, st_reg.pos[15:0]};
            end else if (PADDR == `QCC_ADDR_POS_HIGH) begin
                st_next.rdata = 32'(st_reg.pos[POS_W-1:16]);
            end else if (PADDR == `QCC_ADDR_STATUS) begin
                st_next.rdata = {27'h0000000, cond_b, cond_a,
                                 st_reg.up, st_reg.tick, st_reg.index_hit};
            end else begin
                st_next.rdata = 32'h00000000;
            end
        end

        PREADY  = 1'b1;
        PSLVERR = PSEL && PENABLE
            && PADDR != `QCC_ADDR_CTRL && PADDR != `QCC_ADDR_PHASE
            && PADDR != `QCC_ADDR_POS_LOW && PADDR != `QCC_ADDR_POS_HIGH
            && PADDR != `QCC_ADDR_STATUS;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign PRDATA     = st_reg.rdata;
    assign POSITION   = st_reg.pos;
    assign COUNT_TICK = st_reg.tick;
    assign COUNT_UP   = st_reg.up;
    // Timer modes ignore the init mode field
    assign TIMER_MODE = st_reg.ctrl[`QCC_CCM_MSB];
    assign INIT_MODE  = st_reg.ctrl[`QCC_CCM_MSB] ? 3'h0
        : st_reg.ctrl[`QCC_PIM_MSB:`QCC_PIM_LSB];

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            st_reg       <= '0;
            st_reg.ctrl  <= `QCC_CTRL_RESET;
            st_reg.phase <= `QCC_PHASE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule // qcc_control
`default_nettype wire

// *** qcc_consts.svh ***
// Register offsets, field positions and reset values of the encoder control
`ifndef QCC_CONSTS_SVH
`define QCC_CONSTS_SVH

// ************************************************************
// Register map (byte addresses)
// ************************************************************
`define QCC_ADDR_CTRL      12'h000
`define QCC_ADDR_PHASE     12'h004
`define QCC_ADDR_POS_LOW   12'h008
`define QCC_ADDR_POS_HIGH  12'h00c
`define QCC_ADDR_STATUS    12'h010

// ************************************************************
// Control register fields
// ************************************************************
`define QCC_CCM_LSB        0
`define QCC_CCM_MSB        1
`define QCC_GATE_BIT       2
`define QCC_DIR_BIT        3
`define QCC_DIV_LSB        4
`define QCC_DIV_MSB        6
`define QCC_PIM_LSB        10
`define QCC_PIM_MSB        12
`define QCC_CTRL_WMASK     16'h1c7f
`define QCC_CTRL_RESET     16'h0000

// ************************************************************
// Phase configuration register fields
// ************************************************************
`define QCC_IMV_LSB        0
`define QCC_IMV_MSB        1
`define QCC_SWAP_BIT       2
`define QCC_APOL_BIT       3
`define QCC_BPOL_BIT       4
`define QCC_PHASE_WMASK    16'h001f
`define QCC_PHASE_RESET    16'h0000

`endif

// *** qcc_pkg.sv ***
// Types shared by the encoder counter control files
`default_nettype none
package qcc_pkg;
    typedef enum logic [1:0] {
        QCC_MODE_QUAD   = 2'b00,
        QCC_MODE_EXTDIR = 2'b01,
        QCC_MODE_EXTCLK = 2'b10,
        QCC_MODE_TIMER  = 2'b11
    } qcc_mode_e;

    typedef struct packed {
        qcc_mode_e  mode;
        logic       gate_en;
        logic       dir_inv;
        logic [2:0] div_sel;
        logic [2:0] pim;
    } qcc_cfg_s;

    typedef struct packed {
        logic       phase_a;
        logic       phase_b;
        logic       index;
        logic       ext_clk;
        logic       ext_up;
        logic       gate;
    } qcc_pins_s;
endpackage
`default_nettype wire

// *** qcc_prescaler.sv ***
// Power-of-two prescaler that emits one-cycle count ticks
`default_nettype none
module qcc_prescaler #(
    parameter int DIV_W = 3
) (
    input  wire logic             CLK,
    input  wire logic             RESET,
    input  wire logic [DIV_W-1:0] DIV_SEL,
    output logic                  TICK
);
    localparam int CNT_W = (1 << DIV_W) - 1;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } qcc_pre_state_s;

    qcc_pre_state_s st_reg;
    qcc_pre_state_s st_next;
    logic [CNT_W-1:0] mask;

    if (DIV_W < 1 || DIV_W > 4) begin : g_bad_div
        $error("DIV_W out of range");
    end

    // Divide by 2**DIV_SEL: tick when masked low bits are all zero
    always_comb begin
        mask = CNT_W'((1 << DIV_SEL) - 1);
        st_next = st_reg;
        st_next.cnt = st_reg.cnt + 1'b1;
        TICK = ((st_reg.cnt & mask) == '0);
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule // qcc_prescaler
`default_nettype wire

// *** qcc_phase_cond.sv ***
// Phase swap and polarity conditioning with quadrature edge decode
`default_nettype none
module qcc_phase_cond (
    input  wire logic CLK,
    input  wire logic RESET,
    input  wire logic PHASE_A,
    input  wire logic PHASE_B,
    input  wire logic SWAP,
    input  wire logic A_POL,
    input  wire logic B_POL,
    output logic      COND_A,
    output logic      COND_B,
    output logic      STEP,
    output logic      STEP_UP
);
    typedef struct packed {
        logic a;
        logic b;
        logic valid;
    } qcc_pc_state_s;

    qcc_pc_state_s st_reg;
    qcc_pc_state_s st_next;

    always_comb begin
        // Swap first, then per-phase polarity
        COND_A = (SWAP ? PHASE_B : PHASE_A) ^ A_POL;
        COND_B = (SWAP ? PHASE_A : PHASE_B) ^ B_POL;
        st_next.a = COND_A;
        st_next.b = COND_B;
        st_next.valid = 1'b1;
        // x4: an edge of one phase alone is one step; edges of both phases in one cycle give none
        STEP = st_reg.valid
            && ((COND_A ^ st_reg.a) ^ (COND_B ^ st_reg.b));
        // A leading B counts up
        STEP_UP = st_reg.b ^ COND_A;
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule // qcc_phase_cond
`default_nettype wire

// *** qcc_control_assertions.sv ***
// Port assertions for the encoder counter control block
`default_nettype none
module qcc_control_assertions #(
    parameter int POS_W = 32
) (
    input wire logic             CLK,
    input wire logic             RESET,
    input wire logic             PSEL,
    input wire logic             PENABLE,
    input wire logic             PWRITE,
    input wire logic [11:0]      PADDR,
    input wire logic [31:0]      PRDATA,
    input wire logic             PREADY,
    input wire logic             PSLVERR,
    input wire logic [POS_W-1:0] POSITION,
    input wire logic             COUNT_TICK,
    input wire logic             COUNT_UP,
    input wire logic             TIMER_MODE,
    input wire logic [2:0]       INIT_MODE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    logic acc;
    assign acc = PSEL && PENABLE;
    ready_always_a: assert property (acc |-> PREADY)
        else $error("no ready");
    bad_addr_err_a: assert property (acc && PADDR > 12'h010 |-> PSLVERR)
        else $error("no error on unmapped");
    good_addr_ok_a: assert property (
        acc && PADDR <= 12'h010 && PADDR[1:0] == 2'h0 |-> !PSLVERR)
        else $error("error on mapped");
    bad_read_zero_a: assert property (
        acc && !PWRITE && PADDR > 12'h010 |-> PRDATA == 32'h0)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!(PSEL && !PENABLE) |=> $stable(PRDATA))
        else $error("read data moved");
    init_ignored_a: assert property (TIMER_MODE |-> INIT_MODE == 3'h0)
        else $error("init mode in timer mode");
    count_step_a: assert property (
        COUNT_TICK && |POSITION && !$past(acc && PWRITE) |->
        POSITION == (COUNT_UP ? $past(POSITION) + 1'b1
                              : $past(POSITION) - 1'b1))
        else $error("position step wrong");
    count_still_a: assert property (
        !COUNT_TICK && |POSITION && !$past(acc && PWRITE) |->
        $stable(POSITION))
        else $error("position moved without tick");
endmodule // qcc_control_assertions

bind qcc_control qcc_control_assertions #(.POS_W(POS_W)) u_qcc_ca (
    .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .POSITION(POSITION), .COUNT_TICK(COUNT_TICK),
    .COUNT_UP(COUNT_UP), .TIMER_MODE(TIMER_MODE), .INIT_MODE(INIT_MODE));
`default_nettype wire

// *** qcc_encoder_model.sv ***
// Behavioural quadrature encoder driving the phase pins
`default_nettype none
module qcc_encoder_model (
    input  wire logic CLK,
    input  wire logic RESET,
    input  wire logic STEP,
    input  wire logic FWD,
    output logic      PHASE_A,
    output logic      PHASE_B
);
    logic [1:0] pos_reg;
    // Caller spaces steps, each state lasts several clocks
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET)
            pos_reg <= 2'h0;
        else if (STEP)
            pos_reg <= FWD ? pos_reg + 2'h1 : pos_reg - 2'h1;
    end
    // Gray order, phase A leads when moving forward
    assign PHASE_A = pos_reg[1] ^ pos_reg[0];
    assign PHASE_B = pos_reg[1];
endmodule // qcc_encoder_model
`default_nettype wire

// *** test_qcc_control.sv ***
// Self-checking bench for the encoder counter control block
`default_nettype none
module test_qcc_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CLK = 1'b0, RESET = 1'b1, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, ext_clk = 1'b0, ext_up = 1'b0, gate = 1'b0;
    logic        step = 1'b0, fwd = 1'b0, pa, pb, pready, pslverr, tmode;
    logic        rd_err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_data, position, cf, s;
    logic [15:0] p0, dl, ex, hi;
    logic [2:0]  init_mode;
    logic [1:0]  ep = 2'h0;
    int          err_count = 0, n_checks = 0, seed = 51222;
    qcc_pkg::qcc_pins_s pins;

    always #2 CLK = ~CLK;
    assign pins = {pa, pb, 1'b0, ext_clk, ext_up, gate};

    qcc_control u_qcc_control (
        .CLK(CLK), .RESET(RESET), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PINS(pins),
        .POSITION(position), .COUNT_TICK(), .COUNT_UP(),
        .TIMER_MODE(tmode), .INIT_MODE(init_mode));
    qcc_encoder_model u_qcc_encoder_model (.CLK(CLK), .RESET(RESET),
        .STEP(step), .FWD(fwd), .PHASE_A(pa), .PHASE_B(pb));

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_rng(input string nm, input logic [15:0] lo, up, g);
        n_checks++;
        if ($isunknown(g) || g < lo || g > up) begin
            err_count++;
            $display("unexpected %s: expected %h..%h seen %h", nm, lo, up, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge CLK);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge CLK);
        penable <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            err_count++;
            give_verdict();
        end
    endtask

    task automatic move(input logic f);
        step <= 1'b1;
        fwd <= f;
        @(posedge CLK);
        step <= 1'b0;
        ep = f ? ep + 2'h1 : ep - 2'h1;
        repeat (4) @(posedge CLK);
    endtask

    // Index match on swapped, then polarity-adjusted phases
    function automatic logic hit(input logic [1:0] p, input logic [31:0] c);
        logic a, b;
        a = c[2] ? p[1] : p[1] ^ p[0];
        b = c[2] ? p[1] ^ p[0] : p[1];
        return {a ^ c[3], b ^ c[4]} == c[1:0];
    endfunction

    function automatic logic [15:0] mag(input logic u, input logic [15:0] v);
        return u ? v : 16'h0 - v;
    endfunction

    initial begin
        repeat (12) @(posedge CLK);
        RESET <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl reset", 32'h0, rd_data);
        apb(1'b0, 12'h004, 32'h0);
        chk("phase reset", 32'h0, rd_data);
        apb(1'b1, 12'h014, 32'hffff_ffff);
        chk("unmapped error", 32'h1, {31'h0, rd_err});
        apb(1'b0, 12'h014, 32'h0);
        chk("unmapped read", 32'h0, rd_data);
        for (int i = 0; i < 6; i++) begin
            cf = $random(seed);
            apb(1'b1, 12'h000, cf);
            apb(1'b0, 12'h000, 32'h0);
            chk("ctrl", cf & 32'h1c7f, rd_data);
            chk("timer mode", {31'h0, cf[1]}, {31'h0, tmode});
            chk("init mode", cf[1] ? 32'h0 : cf[12:10], init_mode);
        end
        $display("register test done");
        for (int d = 0; d < 8; d++) begin
            cf = $random(seed);
            gate <= cf[2];
            ext_up <= cf[3];
            apb(1'b1, 12'h000, {25'h0, d[2:0], cf[0], cf[1], 2'h3});
            apb(1'b0, 12'h008, 32'h0);
            p0 = rd_data[15:0];
            repeat (256) @(posedge CLK);
            apb(1'b0, 12'h008, 32'h0);
            dl = mag(cf[3] ^ cf[0], rd_data[15:0] - p0);
            ex = (!cf[1] || cf[2]) ? 16'h0100 >> d : 16'h0;
            hi = |ex ? (16'h0104 >> d) + 16'h1 : 16'h0;
            chk_rng("timer", ex, hi, dl);
        end
        $display("timer test done");
        for (int m = 1; m < 3; m++) begin
            cf = $random(seed);
            ext_up <= cf[0];
            apb(1'b1, 12'h000, {28'h0, cf[1], 1'b0, m[1:0]});
            apb(1'b0, 12'h008, 32'h0);
            p0 = rd_data[15:0];
            repeat (6) begin
                repeat (3) @(posedge CLK);
                ext_clk <= 1'b1;
                repeat (3) @(posedge CLK);
                ext_clk <= 1'b0;
            end
            repeat (4) @(posedge CLK);
            apb(1'b0, 12'h008, 32'h0);
            dl = mag(cf[0] ^ cf[1], rd_data[15:0] - p0);
            chk("ext count", 32'h6, {16'h0, dl});
        end
        $display("external test done");
        for (int w = 0; w < 4; w++) begin
            cf = $random(seed);
            apb(1'b1, 12'h004, {27'h0, cf[4:0]});
            apb(1'b1, 12'h000, {28'h0, cf[5], 3'h0});
            for (int k = 0; k < 4 && !hit(ep, cf); k++)
                move(1'b1);
            apb(1'b0, 12'h00c, 32'h0);
            chk("pos high", 32'h0, rd_data);
            // Clear while the match level holds: the set must win
            apb(1'b1, 12'h010, 32'h1);
            apb(1'b0, 12'h010, 32'h0);
            s = rd_data & 32'h19;
            chk("status", {27'h0, cf[0], cf[1], 3'h1}, s);
            ex = 16'h0;
            repeat (12) begin
                s = $random(seed);
                move(s[0]);
                ex = hit(ep, cf) ? 16'h0 : ex + mag(^{s[0], cf[5:2]}, 16'h1);
                apb(1'b0, 12'h008, 32'h0);
                s = rd_data & 32'hffff;
                chk("quad", {16'h0, ex}, s);
            end
            apb(1'b1, 12'h010, 32'h1);
            apb(1'b0, 12'h010, 32'h0);
            s = rd_data & 32'h1;
            chk("hit flag", {31'h0, hit(ep, cf)}, s);
        end
        $display("quadrature test done");
        give_verdict();
    end
endmodule // test_qcc_control
`default_nettype wire
